// ===== rtl/trig_seq_defines.svh
// Timing constants and field widths for the trigger state sequencer.
`ifndef TRIG_SEQ_DEFINES_SVH
`define TRIG_SEQ_DEFINES_SVH
`define CLK_PERIOD_NS        40
`define LEVEL0_SLOT_NS       900
`define DRIFT_END_NS         2550
`define SHIP_READY_NS        3900
`define SHIP_END_NS          4500
`define RESULT_SEND_NS       6000
`define LEVEL1_SLOT_NS       6400
`define SLOT_WIDTH_NS        200
`define CLEAR_LIMIT_NS       40000
`define MAX_TRACKLETS        40
`define ROI_WIDTH            36
`define ABORT_HOLD_CYCLES    2
// Cycle counts derived from the times above at the reference clock rate.
`define LEVEL0_SLOT_CYC      ((`LEVEL0_SLOT_NS) / (`CLK_PERIOD_NS))
`define DRIFT_END_CYC        ((`DRIFT_END_NS + `CLK_PERIOD_NS - 1) / (`CLK_PERIOD_NS))
`define SHIP_READY_CYC       ((`SHIP_READY_NS) / (`CLK_PERIOD_NS))
`define SHIP_END_CYC         ((`SHIP_END_NS) / (`CLK_PERIOD_NS))
`define RESULT_SEND_CYC      ((`RESULT_SEND_NS) / (`CLK_PERIOD_NS))
`define LEVEL1_SLOT_CYC      ((`LEVEL1_SLOT_NS) / (`CLK_PERIOD_NS))
`define SLOT_WIDTH_CYC       ((`SLOT_WIDTH_NS) / (`CLK_PERIOD_NS))
`define CLEAR_LIMIT_CYC      ((`CLEAR_LIMIT_NS) / (`CLK_PERIOD_NS))
`endif

// ===== rtl/trig_seq_pkg.sv
// Types shared by the trigger state sequencer and its helpers.
package trig_seq_pkg;
    typedef enum logic [3:0] {
        ST_STANDBY,
        ST_WAIT_LEVEL0,
        ST_DRIFT,
        ST_PROCESS,
        ST_SHIP,
        ST_WAIT_RESULT,
        ST_WAIT_LEVEL1,
        ST_READOUT
    } seq_state_t;

    // Clock gates handed to the processing logic.
    typedef struct packed {
        logic archive_en;
        logic preproc_en;
        logic processor_en;
        logic ship_en;
        logic readout_en;
    } clock_gates_t;

    // Trigger candidate sent to the central trigger unit.
    typedef struct packed {
        logic        valid;
        logic        trigger;
        logic [35:0] roi;
    } trigger_result_t;

    // One tracklet word on the shared data path.
    typedef struct packed {
        logic        valid;
        logic [5:0]  index;
        logic [31:0] data;
    } tracklet_word_t;

    // Level-2 decision towards the event buffer.
    typedef struct packed {
        logic accept;
        logic reject;
    } level2_t;
endpackage

// ===== rtl/sync2.sv
// Two flip-flop synchroniser for one level from outside the clock domain.
module sync2
    import trig_seq_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // The first stage feeds only the second stage.
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

// ===== rtl/event_buffer_ctrl.sv
// Event buffer bookkeeping for level-2 decisions, running beside the sequencer.
module event_buffer_ctrl
    import trig_seq_pkg::*;
#(
    parameter int DEPTH = 4
) (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic store,
    input  wire logic level2_accept,
    input  wire logic level2_reject,
    input  wire logic link_ready,
    output logic      ship_valid,
    output logic      buffer_full,
    output logic [$clog2(DEPTH+1)-1:0] used
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [CW-1:0] used;
        logic [CW-1:0] pending;
    } ebuf_state_t;

    ebuf_state_t st;
    ebuf_state_t next_st;
    logic        ship_done;

    assign ship_done = (st.pending != '0) && link_ready;

    // Decisions arrive in event order, so only counts are needed.
    always_comb begin
        next_st = st;
        if (store && st.used != CW'(DEPTH)) begin
            next_st.used = next_st.used + CW'(1);
        end
        if (level2_accept && st.pending != st.used) begin
            next_st.pending = next_st.pending + CW'(1);
        end
        if (level2_reject && st.pending != st.used) begin
            next_st.used = next_st.used - CW'(1);
        end
        if (ship_done) begin
            next_st.pending = next_st.pending - CW'(1);
            next_st.used    = next_st.used - CW'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ship_valid  = st.pending != '0;
    assign buffer_full = st.used == CW'(DEPTH);
    assign used        = st.used;
endmodule

// ===== rtl/trigger_state_sequencer.sv
// Trigger state sequencer: pretrigger to level-1 readout, with level-2 buffer control.
// How it works
// - Rest in stand-by after reset and between events, all processing clocks gated.
// - Pretrigger leaves stand-by, enables sample archival and tracklet preprocessor.
// - Missing level-0 in its slot is a reject: clear and abort.
// - After drift and preprocessing, processor computes tracklets and applies cuts.
// - Selected tracklets transformed and formatted by 3.9 us.
// - Shipping ends by 4.5 us; at most 40 tracklets, extras dropped.
// - Tracklets read out in fixed ascending order.
// - Candidate trigger and 36-bit region vector sent at the 6 us mark.
// - While awaiting level-1, stay busy in ST_WAIT_LEVEL1 with all processing clocks gated.
// - Level-1 reject aborts the event and returns to stand-by.
// - Level-1 accept starts event buffer readout over the tracklet path.
// - Level-1 accept use may be delayed internally to avoid clock noise.
// - Finished readout clears the device back to stand-by unprompted.
// - Level-2 accept schedules buffered event for shipping; reject frees it.
// - Not pipelined: new events ignored until cleared, at worst 40 us.
// - Level-2 shipping runs in parallel, front-end possibly in stand-by.
// - Pretrigger is gated by busy and arrives within 100 ns.
// - Abort signal held for two consecutive clocks aborts at any point.
`include "trig_seq_defines.svh"
module trigger_state_sequencer
    import trig_seq_pkg::*;
#(
    parameter int MAX_TRACKLETS  = `MAX_TRACKLETS,
    parameter int L1_DELAY       = 0,
    parameter int READOUT_WORDS  = 16,
    parameter int CLEAR_LIMIT    = `CLEAR_LIMIT_CYC,
    parameter int EBUF_DEPTH     = 4
) (
    input  wire logic            ref_clk,
    input  wire logic            rst_n,
    input  wire logic            pretrigger,
    input  wire logic            level0_confirm,
    input  wire logic            level1_pulse,
    input  wire logic            level2_accept,
    input  wire logic            level2_reject,
    input  wire logic            abort_trigger_signal,
    input  wire logic            preproc_done,
    input  wire logic [5:0]      tracklet_count,
    input  wire logic [31:0]     tracklet_data,
    input  wire logic [31:0]     readout_data,
    input  wire logic            candidate_trigger,
    input  wire logic [`ROI_WIDTH-1:0] candidate_roi,
    input  wire logic            detector_data_link_ready,
    output clock_gates_t         gates,
    output logic                 busy,
    output tracklet_word_t       path_word,
    output logic                 path_is_readout,
    output trigger_result_t      result,
    output logic                 detector_data_link_valid,
    output logic                 event_buffer_full,
    output logic                 level1_accept,
    output logic                 level1_reject,
    output logic                 level0_reject
);
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] L0_LO   = CNT_W'(`LEVEL0_SLOT_CYC - `SLOT_WIDTH_CYC / 2);
    localparam logic [CNT_W-1:0] L0_HI   = CNT_W'(`LEVEL0_SLOT_CYC + `SLOT_WIDTH_CYC / 2);
    localparam logic [CNT_W-1:0] DRIFT   = CNT_W'(`DRIFT_END_CYC);
    localparam logic [CNT_W-1:0] FMT_END = CNT_W'(`SHIP_READY_CYC);
    localparam logic [CNT_W-1:0] SHIP_END = CNT_W'(`SHIP_END_CYC);
    localparam logic [CNT_W-1:0] SEND_AT = CNT_W'(`RESULT_SEND_CYC);
    localparam logic [CNT_W-1:0] L1_LO   = CNT_W'(`LEVEL1_SLOT_CYC - `SLOT_WIDTH_CYC / 2);
    localparam logic [CNT_W-1:0] L1_HI   = CNT_W'(`LEVEL1_SLOT_CYC + `SLOT_WIDTH_CYC / 2);
    localparam logic [CNT_W-1:0] CLR_LIM = CNT_W'(CLEAR_LIMIT);
    localparam logic [5:0]       TRK_MAX = 6'(MAX_TRACKLETS);
    localparam logic [7:0]       RD_MAX  = 8'(READOUT_WORDS);
    localparam logic [7:0]       L1_DLY  = 8'(L1_DELAY);

    // All sequencer state except the pretrigger edge register in one record.
    typedef struct packed {
        seq_state_t      state;
        logic [CNT_W-1:0] cycle;
        logic            l0_seen;
        logic            l1_seen;
        logic [7:0]      l1_delay;
        logic            l1_held;
        logic [5:0]      ship_limit;
        logic [5:0]      ship_idx;
        logic [7:0]      rd_idx;
        logic            abort_prev;
        tracklet_word_t  word;
        logic            word_is_rd;
        trigger_result_t result;
        logic            l1a;
        logic            l1r;
        logic            l0r;
        logic            store;
    } seq_reg_t;

    seq_reg_t st;
    seq_reg_t next_st;

    logic pretrig_s;
    logic level0_s;
    logic level1_s;
    logic abort_s;
    logic l2a_s;
    logic l2r_s;
    logic pretrig_prev;
    logic pretrig_rise;
    logic abort_now;

    // Trigger pins come from the central trigger fan-out and are synchronised first.
    sync2 u_sync_pre (.ref_clk(ref_clk), .rst_n(rst_n), .d(pretrigger),           .q(pretrig_s));
    sync2 u_sync_l0  (.ref_clk(ref_clk), .rst_n(rst_n), .d(level0_confirm),       .q(level0_s));
    sync2 u_sync_l1  (.ref_clk(ref_clk), .rst_n(rst_n), .d(level1_pulse),         .q(level1_s));
    sync2 u_sync_ab  (.ref_clk(ref_clk), .rst_n(rst_n), .d(abort_trigger_signal), .q(abort_s));
    sync2 u_sync_l2a (.ref_clk(ref_clk), .rst_n(rst_n), .d(level2_accept),        .q(l2a_s));
    sync2 u_sync_l2r (.ref_clk(ref_clk), .rst_n(rst_n), .d(level2_reject),        .q(l2r_s));

    // Edge detect on the synchronised pretrigger so a long pulse starts one event only.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pretrig_prev <= 1'b0;
        end else begin
            pretrig_prev <= pretrig_s;
        end
    end

    assign pretrig_rise = pretrig_s && !pretrig_prev;
    assign abort_now    = abort_s && st.abort_prev;

    // Main sequence; every non-standby state returns to stand-by on abort.
    always_comb begin
        next_st            = st;
        next_st.abort_prev = abort_s;
        next_st.l1a        = 1'b0;
        next_st.l1r        = 1'b0;
        next_st.l0r        = 1'b0;
        next_st.store      = 1'b0;
        next_st.word       = '0;
        next_st.word_is_rd = 1'b0;
        next_st.result.valid = 1'b0;
        if (st.state != ST_STANDBY && st.cycle != '1) begin
            next_st.cycle = st.cycle + CNT_W'(1);
        end
        unique case (st.state)
            ST_STANDBY: begin
                next_st.cycle = '0;
                // Busy is low only here, so a pretrigger elsewhere is ignored.
                if (pretrig_rise) begin
                    next_st.state   = ST_WAIT_LEVEL0;
                    next_st.l0_seen = 1'b0;
                    next_st.l1_seen = 1'b0;
                    next_st.cycle   = CNT_W'(1);
                end
            end
            ST_WAIT_LEVEL0: begin
                if (level0_s && st.cycle >= L0_LO && st.cycle <= L0_HI) begin
                    next_st.l0_seen = 1'b1;
                end
                if (st.cycle > L0_HI && !st.l0_seen) begin
                    next_st.state = ST_STANDBY;
                    next_st.l0r   = 1'b1;
                end else if (st.cycle > L0_HI) begin
                    next_st.state = ST_DRIFT;
                end
            end
            ST_DRIFT: begin
                if (st.cycle >= DRIFT && preproc_done) begin
                    next_st.state = ST_PROCESS;
                end
            end
            ST_PROCESS: begin
                // Excess tracklets beyond the chamber limit are never shipped.
                next_st.ship_limit = (tracklet_count > TRK_MAX) ? TRK_MAX : tracklet_count;
                next_st.ship_idx   = '0;
                if (st.cycle >= FMT_END) begin
                    next_st.state = ST_SHIP;
                end
            end
            ST_SHIP: begin
                if (st.ship_idx < st.ship_limit && st.cycle < SHIP_END) begin
                    next_st.word.valid = 1'b1;
                    next_st.word.index = st.ship_idx;
                    next_st.word.data  = tracklet_data;
                    next_st.ship_idx   = st.ship_idx + 6'd1;
                end else begin
                    next_st.state = ST_WAIT_RESULT;
                end
            end
            ST_WAIT_RESULT: begin
                if (st.cycle >= SEND_AT) begin
                    next_st.result.valid   = 1'b1;
                    next_st.result.trigger = candidate_trigger;
                    next_st.result.roi     = candidate_roi;
                    next_st.state          = ST_WAIT_LEVEL1;
                end
            end
            ST_WAIT_LEVEL1: begin
                if (level1_s && st.cycle >= L1_LO && st.cycle <= L1_HI) begin
                    next_st.l1_seen = 1'b1;
                end
                if (st.cycle > L1_HI && !st.l1_seen) begin
                    next_st.state = ST_STANDBY;
                    next_st.l1r   = 1'b1;
                end else if (st.cycle > L1_HI) begin
                    next_st.l1a      = 1'b1;
                    next_st.l1_delay = '0;
                    next_st.l1_held  = 1'b1;
                    next_st.rd_idx   = '0;
                    next_st.state    = ST_READOUT;
                end
            end
            ST_READOUT: begin
                if (st.l1_held && st.l1_delay < L1_DLY) begin
                    next_st.l1_delay = st.l1_delay + 8'd1;
                end else if (st.rd_idx < RD_MAX) begin
                    next_st.l1_held    = 1'b0;
                    next_st.word.valid = 1'b1;
                    next_st.word.index = st.rd_idx[5:0];
                    next_st.word.data  = readout_data;
                    next_st.word_is_rd = 1'b1;
                    next_st.rd_idx     = st.rd_idx + 8'd1;
                end else begin
                    next_st.store = 1'b1;
                    next_st.state = ST_STANDBY;
                end
            end
        endcase
        // A stuck event is cleared once the worst-case accept time has passed.
        if (st.state != ST_STANDBY && st.cycle >= CLR_LIM) begin
            next_st.state = ST_STANDBY;
        end
        if (abort_now && st.state != ST_STANDBY) begin
            next_st.state = ST_STANDBY;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Clock gates follow the state; waiting for level-1 keeps everything off.
    always_comb begin
        gates              = '0;
        gates.archive_en   = st.state == ST_WAIT_LEVEL0 || st.state == ST_DRIFT;
        gates.preproc_en   = st.state == ST_WAIT_LEVEL0 || st.state == ST_DRIFT;
        gates.processor_en = st.state == ST_PROCESS;
        gates.ship_en      = st.state == ST_SHIP;
        gates.readout_en   = st.state == ST_READOUT && !st.l1_held;
    end

    assign busy            = st.state != ST_STANDBY;
    assign path_word       = st.word;
    assign path_is_readout = st.word_is_rd;
    assign result          = st.result;
    assign level1_accept   = st.l1a;
    assign level1_reject   = st.l1r;
    assign level0_reject   = st.l0r;

    // Level-2 handling is independent of the front-end sequence.
    event_buffer_ctrl #(
        .DEPTH(EBUF_DEPTH)
    ) u_ebuf (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .store        (st.store),
        .level2_accept(l2a_s),
        .level2_reject(l2r_s),
        .link_ready   (detector_data_link_ready),
        .ship_valid   (detector_data_link_valid),
        .buffer_full  (event_buffer_full),
        .used         ()
    );
endmodule

// ===== tb/seq_checker_props.sv
// Concurrent checks on the trigger state sequencer ports.
module seq_checker
    import trig_seq_pkg::*;
#(
    parameter int MAX_TRACKLETS = 40,
    parameter int CLEAR_LIMIT   = 1000
) (
    input wire logic            ref_clk,
    input wire logic            rst_n,
    input wire logic            abort_trigger_signal,
    input wire clock_gates_t    gates,
    input wire logic            busy,
    input wire tracklet_word_t  path_word,
    input wire logic            path_is_readout,
    input wire trigger_result_t result,
    input wire logic            level1_accept,
    input wire logic            level1_reject,
    input wire logic            level0_reject
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned run_cnt;

    // Busy cycles since the pretrigger; one behind the device's own count.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            run_cnt <= 0;
        else
            run_cnt <= busy ? run_cnt + 1 : 0;
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence abort_held;
        abort_trigger_signal [*2];
    endsequence
    sequence readout_word;
        path_word.valid && path_is_readout;
    endsequence

    idle_gates_off_a: assert property (!busy |-> gates == '0)
        else $error("clock gates open in stand-by");
    wake_gates_on_a: assert property ($rose(busy) |-> gates.archive_en && gates.preproc_en)
        else $error("archive or preprocessor not enabled at wake-up");
    proc_after_drift_a: assert property (gates.processor_en |-> run_cnt >= 62)
        else $error("processor enabled before drift end");
    ship_limit_a: assert property (path_word.valid && !path_is_readout
        |-> run_cnt <= 112 && path_word.index < MAX_TRACKLETS)
        else $error("tracklet word late or beyond limit");
    ordered_words_a: assert property (path_word.valid && $past(path_word.valid)
        && path_is_readout == $past(path_is_readout)
        |-> path_word.index == $past(path_word.index) + 6'h01)
        else $error("words out of order");
    result_slot_a: assert property (result.valid |-> run_cnt >= 148)
        else $error("result sent early");
    level1_quiet_a: assert property (result.valid |=> gates.processor_en == 1'b0
        && gates.ship_en == 1'b0 && gates.readout_en == 1'b0)
        else $error("fast clocks on while awaiting level-1");
    level0_abort_a: assert property (level0_reject |-> ##[0:1] !busy)
        else $error("no stand-by after level-0 reject");
    level1_abort_a: assert property (level1_reject |-> ##[0:1] !busy)
        else $error("no stand-by after level-1 reject");
    readout_start_a: assert property (level1_accept |-> ##[0:3] readout_word)
        else $error("readout not started");
    readout_clear_a: assert property (level1_accept |-> ##[16:40] !busy)
        else $error("no stand-by after readout");
    abort_held_a: assert property (abort_held |-> ##[1:5] !busy)
        else $error("held abort ignored");
    clear_bound_a: assert property (run_cnt <= CLEAR_LIMIT + 2)
        else $error("sequence not cleared in time");
endmodule

bind trigger_state_sequencer seq_checker #(.MAX_TRACKLETS(MAX_TRACKLETS),
    .CLEAR_LIMIT(CLEAR_LIMIT)) checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .abort_trigger_signal(abort_trigger_signal), .gates(gates), .busy(busy),
    .path_word(path_word), .path_is_readout(path_is_readout), .result(result),
    .level1_accept(level1_accept), .level1_reject(level1_reject),
    .level0_reject(level0_reject));

// ===== tb/ctu_model.sv
// Behavioural central trigger unit giving level-0 and level-1 in their slots.
module ctu_model (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic busy,
    input  wire logic give_l0,
    input  wire logic give_l1,
    output logic      level0_confirm,
    output logic      level1_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned n;

    // Cycles since wake-up; the slots are fixed offsets from the pretrigger.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            n <= 0;
        else
            n <= busy ? n + 1 : 0;
    end

    // A decision is only ever a pulse inside its slot; absence means reject.
    always @(negedge ref_clk) begin
        level0_confirm <= give_l0 && busy && n >= 15 && n <= 18;
        level1_pulse <= give_l1 && busy && n >= 155 && n <= 159;
    end
endmodule

// ===== tb/trigger_state_sequencer_tb.sv
// Self-checking bench for the trigger state sequencer.
`include "trig_seq_defines.svh"
module trigger_state_sequencer_tb
    import trig_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0]  kind;
        logic [5:0]  idx;
        logic [35:0] val;
    } note_t;
    logic ref_clk = 1'b0, rst_n = 1'b0, pretrigger = 1'b0, abort_trigger_signal = 1'b0;
    logic level2_accept = 1'b0, level2_reject = 1'b0, preproc_done = 1'b0;
    logic candidate_trigger = 1'b0, detector_data_link_ready = 1'b0;
    logic give_l0 = 1'b0, give_l1 = 1'b0, level0_confirm, level1_pulse;
    logic [5:0] tracklet_count = 6'h00;
    logic [31:0] tracklet_data = 32'h0, readout_data = 32'h0;
    logic [35:0] candidate_roi = 36'h0;
    clock_gates_t gates;
    tracklet_word_t path_word;
    trigger_result_t result;
    logic busy, path_is_readout, detector_data_link_valid, event_buffer_full;
    logic level1_accept, level1_reject, level0_reject;
    note_t q[$];
    int n_fail = 0, checks = 0;
    logic [16:0] lf = 17'h15E1F;

    trigger_state_sequencer #(.L1_DELAY(2)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .pretrigger(pretrigger), .level0_confirm(level0_confirm), .level1_pulse(level1_pulse),
        .level2_accept(level2_accept), .level2_reject(level2_reject),
        .abort_trigger_signal(abort_trigger_signal), .preproc_done(preproc_done),
        .tracklet_count(tracklet_count), .tracklet_data(tracklet_data),
        .readout_data(readout_data), .candidate_trigger(candidate_trigger),
        .candidate_roi(candidate_roi), .detector_data_link_ready(detector_data_link_ready),
        .gates(gates), .busy(busy), .path_word(path_word), .path_is_readout(path_is_readout),
        .result(result), .detector_data_link_valid(detector_data_link_valid),
        .event_buffer_full(event_buffer_full), .level1_accept(level1_accept),
        .level1_reject(level1_reject), .level0_reject(level0_reject));
    ctu_model ctu (.ref_clk(ref_clk), .rst_n(rst_n), .busy(busy), .give_l0(give_l0),
        .give_l1(give_l1), .level0_confirm(level0_confirm), .level1_pulse(level1_pulse));

    // Free-running 25 MHz reference clock.
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // Shift register source; the upper half is the lower half one step earlier, not fresh bits.
    function automatic logic [31:0] rnd();
        logic [15:0] hi;
        lf = {lf[15:0], lf[16] ^ lf[13]};
        hi = lf[15:0];
        lf = {lf[15:0], lf[16] ^ lf[13]};
        return {hi, lf[15:0]};
    endfunction

    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic compare(input note_t got);
        if (q.size() == 0) begin
            check(1'b0, "output with no expectation");
        end else begin
            check(got === q.pop_front(), "output differs from expectation");
        end
    endtask

    task automatic wait_cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Every visible result is taken against the oldest note, in a fixed order.
    always @(negedge ref_clk) begin
        if (rst_n === 1'b1) begin
            if (level0_reject === 1'b1) compare({3'h1, 6'h00, 36'h0});
            if (level1_reject === 1'b1) compare({3'h3, 6'h00, 36'h0});
            if (level1_accept === 1'b1) compare({3'h2, 6'h00, 36'h0});
            if (result.valid === 1'b1) compare({3'h6, 5'h00, result.trigger, result.roi});
            if (path_word.valid === 1'b1)
                compare({path_is_readout ? 3'h5 : 3'h4, path_word.index, 4'h0, path_word.data});
        end
    end

    // One sequence; abort_at above zero holds abort two cycles, below zero glitches it.
    task automatic run_event(input logic [5:0] cnt, input logic l0, input logic l1,
                             input int abort_at);
        int t;
        logic [31:0] r;
        r = rnd();
        tracklet_count = cnt;
        tracklet_data = rnd();
        readout_data = rnd();
        candidate_trigger = r[4];
        candidate_roi = {r[3:0], rnd()};
        if (!l0) begin
            q.push_back({3'h1, 6'h00, 36'h0});
        end else if (abort_at <= 0) begin
            for (int i = 0; i < cnt && i < 40 && i < `SHIP_END_CYC - `SHIP_READY_CYC - 1; i++)
                q.push_back({3'h4, 6'(i), 4'h0, tracklet_data});
            q.push_back({3'h6, 5'h00, candidate_trigger, candidate_roi});
            if (l1) begin
                q.push_back({3'h2, 6'h00, 36'h0});
                for (int i = 0; i < 16; i++)
                    q.push_back({3'h5, 6'(i), 4'h0, readout_data});
            end else begin
                q.push_back({3'h3, 6'h00, 36'h0});
            end
        end
        give_l0 = l0;
        give_l1 = l1;
        preproc_done = 1'b0;
        pretrigger = 1'b1;
        wait_cycles(2);
        pretrigger = 1'b0;
        t = 0;
        while (busy !== 1'b1 && t < 10) begin
            wait_cycles(1);
            t++;
        end
        check(busy === 1'b1, "pretrigger not taken");
        t = 0;
        while (busy === 1'b1 && t < 600) begin
            wait_cycles(1);
            t++;
            preproc_done = (t >= 50);
            pretrigger = (t == 40 || t == 41);
            abort_trigger_signal = (abort_at > 0 && (t == abort_at || t == abort_at + 1))
                || t == -abort_at;
        end
        pretrigger = 1'b0;
        abort_trigger_signal = 1'b0;
        wait_cycles(10);
        check(busy === 1'b0, "no return to stand-by");
        check(q.size() == 0, "expected outputs missing");
        $display("test done: count %0d l0 %0d l1 %0d abort %0d", cnt, l0, l1, abort_at);
    endtask

    // Level-2 decisions arrive as one-cycle pulses.
    task automatic level2_pulse(input logic acc);
        level2_accept = acc;
        level2_reject = !acc;
        wait_cycles(1);
        level2_accept = 1'b0;
        level2_reject = 1'b0;
        wait_cycles(6);
    endtask

    task automatic finish_test();
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Seven sequences take about a thousand cycles; this span means a hang.
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end

    // Four stored events fill the buffer; rejects and aborts must store nothing.
    initial begin
        wait_cycles(3);
        rst_n = 1'b1;
        wait_cycles(2);
        check(busy === 1'b0 && gates === '0, "not idle after reset");
        run_event(6'h2D, 1'b1, 1'b1, 0);
        run_event(6'h28, 1'b1, 1'b1, 0);
        run_event(6'h00, 1'b1, 1'b1, 0);
        run_event(6'(rnd()), 1'b1, 1'b1, 0);
        check(event_buffer_full === 1'b1, "buffer not full");
        run_event(6'(rnd()), 1'b1, 1'b0, -20);
        run_event(6'h05, 1'b0, 1'b0, 0);
        run_event(6'h0A, 1'b1, 1'b1, 30);
        level2_pulse(1'b0);
        check(event_buffer_full === 1'b0, "reject kept space");
        check(detector_data_link_valid === 1'b0, "shipping without accept");
        level2_pulse(1'b1);
        wait_cycles(20);
        check(detector_data_link_valid === 1'b1 && busy === 1'b0, "no shipping");
        detector_data_link_ready = 1'b1;
        wait_cycles(3);
        check(detector_data_link_valid === 1'b0, "event not removed");
        $display("test done: level-2 buffer");
        finish_test();
    end
endmodule
